// ### logic/umspi_defs.svh
// Register offsets, field positions and reset values of the SPI engine
`ifndef UMSPI_DEFS_SVH
`define UMSPI_DEFS_SVH

// Byte offsets of the register words
`define UMSPI_OFS_DATA      8'h00
`define UMSPI_OFS_STATUS    8'h04
`define UMSPI_OFS_CTRL_EN   8'h08
`define UMSPI_OFS_MODE      8'h0C
`define UMSPI_OFS_BAUD      8'h10

// Status field positions
`define UMSPI_ST_RXC        7
`define UMSPI_ST_TXC        6
`define UMSPI_ST_DRE        5

// Enable register field positions
`define UMSPI_EN_RXCIE      7
`define UMSPI_EN_TXCIE      6
`define UMSPI_EN_DREIE      5
`define UMSPI_EN_RXEN       4
`define UMSPI_EN_TXEN       3

// Mode register field positions
`define UMSPI_MD_SEL_HI     7
`define UMSPI_MD_SEL_LO     6
`define UMSPI_MD_ORDER      2
`define UMSPI_MD_CPHA       1
`define UMSPI_MD_CPOL       0

// Reset values and constant read fields
`define UMSPI_EN_RESET      8'h06
`define UMSPI_EN_RSVD       3'h6
`define UMSPI_MD_RESET      8'h06
`define UMSPI_BAUD_RESET    12'h000
`define UMSPI_MODE_SPI      2'h3
`define UMSPI_FRAME_LAST    3'h7
`define UMSPI_RX_DEPTH      2

`endif

// ### logic/umspi_pkg.sv
// Types shared by the SPI engine modules
package umspi_pkg;

    // Latched AHB address phase
    typedef struct packed {
        logic       valid;  // Transfer pending in data phase
        logic       wr;     // Write transfer
        logic [7:0] addr;   // Low byte address
    } umspi_ap_t;

    // Frame format settings
    typedef struct packed {
        logic [1:0] sel;        // Mode select field
        logic       lsb_first;  // Bit order select
        logic       cpha;       // Clock phase bit
        logic       cpol;       // Clock polarity bit
    } umspi_mode_t;

    // Shift engine states, one-hot
    typedef enum logic [2:0] {
        UMSPI_IDLE  = 3'b001,
        UMSPI_LEAD  = 3'b010,
        UMSPI_TRAIL = 3'b100
    } umspi_state_t;

endpackage

// ### logic/umspi_baud.sv
// Half-period tick generator for the transfer clock
`timescale 1ns/1ps
module umspi_baud (
    input  wire logic        core_clk,
    input  wire logic        reset,
    input  wire logic        restart,   // Realign at frame start
    input  wire logic [11:0] divisor,   // Baud divisor
    output logic             half_tick  // One pulse per half period
);
    logic [11:0] cnt_r; // Cycles into the half period

    // Tick after divisor+1 cycles: rate is clock / (2 * (divisor + 1))
    // Restart only clears the count: gating the tick with it would loop through frame start
    assign half_tick = (cnt_r >= divisor); // RULE22 RULE12

    // Counter restarts so the first half period is full length
    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            cnt_r <= 12'h000;
        end else if (restart || half_tick) begin
            cnt_r <= 12'h000;
        end else begin
            cnt_r <= cnt_r + 12'h001;
        end
    end

    property p_tick_gap;
        @(posedge core_clk) disable iff (reset)
        half_tick && divisor != 12'h000 |=> !half_tick;
    endproperty
    a_tick_gap: assert property (p_tick_gap) // RULE22
        else $error("half tick came too soon");
endmodule

// ### logic/umspi_rxbuf.sv
// Receive buffer with two levels beyond the shift register
`timescale 1ns/1ps
`include "umspi_defs.svh"
module umspi_rxbuf (
    input  wire logic       core_clk,
    input  wire logic       reset,
    input  wire logic       flush,     // Receiver disabled
    input  wire logic       push,      // Frame complete
    input  wire logic [7:0] push_data, // Received frame
    input  wire logic       pop,       // Data register read
    output logic [7:0]      head,      // Oldest unread frame
    output logic            not_empty  // Unread data present
);
    logic [7:0] mem [`UMSPI_RX_DEPTH]; // Storage words
    logic       wr_ptr_r;              // Next free slot
    logic       rd_ptr_r;              // Oldest slot
    logic [1:0] count_r;               // Frames held
    logic       full;                  // No room left
    logic       do_push;               // Accepted push
    logic       do_pop;                // Accepted pop

    assign full      = (count_r == 2'h2);
    assign not_empty = (count_r != 2'h0); // RULE15
    assign head      = mem[rd_ptr_r];
    // Newest frame dropped when full, older ones kept
    assign do_push   = push && !full && !flush; // RULE8
    assign do_pop    = pop && not_empty;

    // Storage write, no reset needed on data
    always_ff @(posedge core_clk) begin
        if (do_push) begin
            mem[wr_ptr_r] <= push_data;
        end
    end

    // Pointers and occupancy; flush empties at once
    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            wr_ptr_r <= 1'b0;
            rd_ptr_r <= 1'b0;
            count_r  <= 2'h0;
        end else if (flush) begin
            wr_ptr_r <= 1'b0;
            rd_ptr_r <= 1'b0;
            count_r  <= 2'h0; // RULE15
        end else begin
            if (do_push) begin
                wr_ptr_r <= ~wr_ptr_r;
            end
            if (do_pop) begin
                rd_ptr_r <= ~rd_ptr_r;
            end
            count_r <= count_r + {1'b0, do_push} - {1'b0, do_pop};
        end
    end

    property p_keep_old;
        @(posedge core_clk) disable iff (reset)
        full && push && !pop && !flush |=> full && $stable(head);
    endproperty
    a_keep_old: assert property (p_keep_old) // RULE8
        else $error("overflow disturbed the older frames");
endmodule

// ### logic/umspi_top.sv
// Master-only SPI engine with AHB-Lite register access
// Behaviour
// RULE1 - Software enables transmitter before any transfer
// RULE2 - Transmitter enable claims serial output pin
// RULE3 - Receiver enable claims serial input pin
// RULE4 - Clock always driven, shared shift and sample; here driven only while transmitter owns pins in spi mode
// RULE5 - Data register write starts full-duplex frame
// RULE6 - Buffer loads shifter only when shifter free
// RULE7 - Software reads data once per frame
// RULE8 - Overflow drops newest frame, keeps older
// RULE9 - Framing, overrun, parity flags read zero
// RULE10 - Double-buffered transmit, two-level receive
// RULE11 - No write-collision flag exists
// RULE12 - No double-speed bit; divisor sets rate
// RULE13 - Master only, no slave select pin
// RULE14 - Polarity, phase, order act like SPI master
// RULE15 - Receive-complete tracks buffer, cleared by disable
// RULE16 - Transmit-complete sets when idle, clears on ack
// RULE17 - Data-empty high when buffer free, after reset
// RULE18 - Software writes zero to status reserved bits
// RULE19 - Enable register layout, bits seven to three
// RULE20 - Interrupt requests gated by enable and global
// RULE21 - Spi mode only when select field is three
// RULE22 - Clock rate is clock over 2(divisor+1)
// RULE23 - Shift and sample on opposite clock edges
// RULE24 - Eight data bits, order selectable, shared
// RULE25 - Idle clock at polarity, output held steady
`timescale 1ns/1ps
`include "umspi_defs.svh"
module umspi_top (
    input  wire logic        core_clk,
    input  wire logic        reset,
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    output logic [31:0]      hrdata,
    output logic             hreadyout,
    output logic             hresp,
    input  wire logic        hready,
    input  wire logic        global_irq_enable,
    input  wire logic        txc_irq_taken,
    output logic             rxc_irq_req,
    output logic             txc_irq_req,
    output logic             dre_irq_req,
    output logic             transfer_clock_pin,
    output logic             transfer_clock_oe,
    output logic             serial_out_pin,
    output logic             serial_out_oe,
    input  wire logic        serial_in_pin,
    output logic             serial_in_claim
);
    // Bus side
    umspi_pkg::umspi_ap_t    ap_r;       // Address phase in flight
    logic                    rd_done_r;  // Read data registered
    logic [31:0]             hrdata_r;   // Read data word
    logic                    ap_take;    // New address phase accepted
    logic                    wr_now;     // Write data phase completing
    // Registers
    logic [7:0]              en_r;       // Enables register
    umspi_pkg::umspi_mode_t  mode_r;     // Frame format
    logic [11:0]             baud_r;     // Baud divisor
    logic                    txc_r;      // Transmit-complete flag
    logic [7:0]              txbuf_r;    // Transmit holding register
    logic                    tx_full_r;  // Holding register occupied
    logic                    tx_on_r;    // Transmitter owns the pins
    // Shift engine
    umspi_pkg::umspi_state_t state_r;    // Engine state
    umspi_pkg::umspi_state_t state_nxt;  // Next engine state
    logic [7:0]              tx_sh_r;    // Transmit shifter
    logic [7:0]              rx_sh_r;    // Receive shifter
    logic [2:0]              bit_r;      // Bit within frame
    logic                    mosi_r;     // Serial output level
    logic                    half_tick;  // Half period elapsed
    logic                    mode_on;    // Spi mode selected
    logic                    start;      // Load shifter this cycle
    logic                    lead_edge;  // Leading clock edge now
    logic                    trail_edge; // Trailing clock edge now
    logic                    frame_done; // Last trailing edge
    logic                    drive;      // Put next bit out
    logic                    sample;     // Take input bit
    logic [7:0]              rx_shifted; // Shifter with new bit
    logic [7:0]              rx_head;    // Oldest received frame
    logic                    rxc;        // Unread data present
    logic                    rx_pop;     // Data register read
    logic [3:0]              sck_edges_r; // Clock edges this frame

    // Output bit picked by bit order
    function automatic logic out_bit(input logic [7:0] sh, input logic lsb);
        out_bit = lsb ? sh[0] : sh[7];
    endfunction

    // Shift toward the exit end by bit order
    function automatic logic [7:0] shift8(input logic [7:0] sh, input logic lsb,
                                          input logic din);
        shift8 = lsb ? {din, sh[7:1]} : {sh[6:0], din};
    endfunction

    assign mode_on = (mode_r.sel == `UMSPI_MODE_SPI); // RULE21

    // AHB-Lite slave: writes zero wait, reads one wait state
    assign ap_take   = hsel && htrans[1] && hready;
    assign hreadyout = !(ap_r.valid && !ap_r.wr && !rd_done_r);
    assign hresp     = 1'b0;
    assign hrdata    = hrdata_r;
    assign wr_now    = ap_r.valid && ap_r.wr;

    // Address phase capture
    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            ap_r <= '0;
        end else if (hready) begin
            ap_r.valid <= ap_take;
            ap_r.wr    <= hwrite;
            ap_r.addr  <= haddr[7:0];
        end
    end

    // Read mux into the data flop; data read pops the receive buffer
    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            hrdata_r  <= 32'h0000_0000;
            rd_done_r <= 1'b0;
        end else if (ap_r.valid && !ap_r.wr && !rd_done_r) begin
            rd_done_r <= 1'b1;
            unique case (ap_r.addr)
                `UMSPI_OFS_DATA:    hrdata_r <= {24'h00_0000, rx_head};
                // Error flags are absent and read as zero
                `UMSPI_OFS_STATUS:  hrdata_r <= {24'h00_0000, rxc, txc_r,
                                                 !tx_full_r, 5'h00}; // RULE9
                `UMSPI_OFS_CTRL_EN: hrdata_r <= {24'h00_0000, en_r[7:3],
                                                 `UMSPI_EN_RSVD}; // RULE19
                `UMSPI_OFS_MODE:    hrdata_r <= {24'h00_0000, mode_r.sel, 3'h0,
                                                 mode_r.lsb_first, mode_r.cpha,
                                                 mode_r.cpol};
                `UMSPI_OFS_BAUD:    hrdata_r <= {20'h0_0000, baud_r};
                default:            hrdata_r <= 32'h0000_0000;
            endcase
        end else begin
            rd_done_r <= 1'b0;
        end
    end

    // Pop only once, in the first data-phase cycle
    assign rx_pop = ap_r.valid && !ap_r.wr && !rd_done_r
                    && (ap_r.addr == `UMSPI_OFS_DATA); // RULE7

    // Control registers; reserved bits are not stored
    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            en_r   <= `UMSPI_EN_RESET & 8'hF8;
            mode_r <= '{sel: 2'h0, lsb_first: 1'b1, cpha: 1'b1, cpol: 1'b0};
            baud_r <= `UMSPI_BAUD_RESET;
        end else if (wr_now) begin
            unique case (ap_r.addr)
                `UMSPI_OFS_CTRL_EN: en_r <= {hwdata[7:3], 3'h0}; // RULE19
                `UMSPI_OFS_MODE:    mode_r <= '{sel: hwdata[7:6],
                                                lsb_first: hwdata[2],
                                                cpha: hwdata[1],
                                                cpol: hwdata[0]}; // RULE14
                `UMSPI_OFS_BAUD:    baud_r <= hwdata[11:0]; // RULE12
                default:            ;
            endcase
        end
    end

    // Holding register: a write queues a byte, a load frees it
    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            txbuf_r   <= 8'h00;
            tx_full_r <= 1'b0;
        end else if (wr_now && ap_r.addr == `UMSPI_OFS_DATA && !tx_full_r) begin
            // Write while full is ignored, no collision flag
            txbuf_r   <= hwdata[7:0]; // RULE5 RULE11
            tx_full_r <= 1'b1; // RULE10
        end else if (start) begin
            tx_full_r <= 1'b0; // RULE6
        end
    end

    // Transmitter stays on until pending frames drain after disable
    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            tx_on_r <= 1'b0;
        end else begin
            tx_on_r <= en_r[`UMSPI_EN_TXEN] || (tx_on_r && (tx_full_r
                       || state_r != umspi_pkg::UMSPI_IDLE)); // RULE1
        end
    end

    // Transmit-complete: hardware set wins over the clears
    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            txc_r <= 1'b0;
        end else if (frame_done && !tx_full_r) begin
            txc_r <= 1'b1; // RULE16
        end else if (txc_irq_taken || (wr_now && ap_r.addr == `UMSPI_OFS_STATUS
                                       && hwdata[`UMSPI_ST_TXC])) begin
            txc_r <= 1'b0; // RULE16
        end
    end

    umspi_baud u_baud (
        .core_clk  (core_clk),
        .reset     (reset),
        .restart   (start),
        .divisor   (baud_r),
        .half_tick (half_tick)
    );

    // Frame start needs an owning transmitter; receiver alone never clocks
    assign start      = (state_r == umspi_pkg::UMSPI_IDLE || frame_done)
                        && tx_full_r && tx_on_r && mode_on; // RULE1 RULE5
    assign lead_edge  = (state_r == umspi_pkg::UMSPI_LEAD) && half_tick;
    assign trail_edge = (state_r == umspi_pkg::UMSPI_TRAIL) && half_tick;
    assign frame_done = trail_edge && (bit_r == `UMSPI_FRAME_LAST); // RULE24
    // Phase 0 samples leading, phase 1 samples trailing
    assign sample     = mode_r.cpha ? trail_edge : lead_edge; // RULE23
    assign drive      = mode_r.cpha ? lead_edge
                        : (trail_edge && bit_r != `UMSPI_FRAME_LAST); // RULE23
    assign rx_shifted = shift8(rx_sh_r, mode_r.lsb_first, serial_in_pin); // RULE24

    // Engine state sequence: wait lead edge, wait trail edge
    always_comb begin
        state_nxt = state_r;
        unique case (state_r)
            umspi_pkg::UMSPI_IDLE:  if (start) state_nxt = umspi_pkg::UMSPI_LEAD;
            umspi_pkg::UMSPI_LEAD:  if (lead_edge) state_nxt = umspi_pkg::UMSPI_TRAIL;
            umspi_pkg::UMSPI_TRAIL: begin
                if (start) begin
                    state_nxt = umspi_pkg::UMSPI_LEAD; // RULE6
                end else if (frame_done) begin
                    state_nxt = umspi_pkg::UMSPI_IDLE;
                end else if (trail_edge) begin
                    state_nxt = umspi_pkg::UMSPI_LEAD;
                end
            end
            default: state_nxt = umspi_pkg::UMSPI_IDLE;
        endcase
    end

    // State register; leaving spi mode aborts the frame
    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            state_r <= umspi_pkg::UMSPI_IDLE;
        end else if (!mode_on) begin
            state_r <= umspi_pkg::UMSPI_IDLE; // RULE21
        end else begin
            state_r <= state_nxt;
        end
    end

    // Bit counter advances on trailing edges
    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            bit_r <= 3'h0;
        end else if (start) begin
            bit_r <= 3'h0;
        end else if (trail_edge) begin
            bit_r <= bit_r + 3'h1; // RULE24
        end
    end

    // Transmit shifter; output moves on a drive or a phase 0 start, steady between frames
    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            tx_sh_r <= 8'h00;
            mosi_r  <= 1'b1;
        end else if (start && !mode_r.cpha) begin
            // Phase 0 presents the first bit before the leading edge
            mosi_r  <= out_bit(txbuf_r, mode_r.lsb_first); // RULE23
            tx_sh_r <= shift8(txbuf_r, mode_r.lsb_first, 1'b0);
        end else if (start) begin
            tx_sh_r <= txbuf_r; // RULE6
        end else if (drive) begin
            mosi_r  <= out_bit(tx_sh_r, mode_r.lsb_first); // RULE2
            tx_sh_r <= shift8(tx_sh_r, mode_r.lsb_first, 1'b0);
        end
    end

    // Receive shifter shares the transfer clock
    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            rx_sh_r <= 8'h00;
        end else if (sample) begin
            rx_sh_r <= rx_shifted; // RULE4
        end
    end

    umspi_rxbuf u_rxbuf (
        .core_clk  (core_clk),
        .reset     (reset),
        .flush     (!en_r[`UMSPI_EN_RXEN]),
        .push      (frame_done && en_r[`UMSPI_EN_RXEN]),
        .push_data (mode_r.cpha ? rx_shifted : rx_sh_r),
        .pop       (rx_pop),
        .head      (rx_head),
        .not_empty (rxc)
    );

    // Pins: clock idles at polarity, no slave select exists
    assign transfer_clock_pin = mode_r.cpol
                                ^ (state_r == umspi_pkg::UMSPI_TRAIL); // RULE25 RULE14
    assign transfer_clock_oe  = tx_on_r && mode_on; // RULE4 RULE13
    assign serial_out_pin     = mosi_r;
    assign serial_out_oe      = tx_on_r && mode_on; // RULE2
    assign serial_in_claim    = en_r[`UMSPI_EN_RXEN] && mode_on; // RULE3

    // Interrupt requests; the global enable lives outside the block
    assign rxc_irq_req = en_r[`UMSPI_EN_RXCIE] && global_irq_enable && rxc; // RULE20
    assign txc_irq_req = en_r[`UMSPI_EN_TXCIE] && global_irq_enable && txc_r;
    assign dre_irq_req = en_r[`UMSPI_EN_DREIE] && global_irq_enable
                         && !tx_full_r; // RULE17

    // Helper for checks: clock transitions seen in the frame
    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            sck_edges_r <= 4'h0;
        end else if (start) begin
            sck_edges_r <= 4'h0;
        end else if (half_tick && state_r != umspi_pkg::UMSPI_IDLE) begin
            sck_edges_r <= sck_edges_r + 4'h1;
        end
    end

    property p_sck_idle;
        @(posedge core_clk) disable iff (reset)
        state_r == umspi_pkg::UMSPI_IDLE |-> transfer_clock_pin == mode_r.cpol;
    endproperty
    a_sck_idle: assert property (p_sck_idle) // RULE25
        else $error("clock not at idle level between frames");

    property p_frame_edges;
        @(posedge core_clk) disable iff (reset)
        frame_done |-> sck_edges_r == 4'hF;
    endproperty
    a_frame_edges: assert property (p_frame_edges) // RULE24
        else $error("frame did not span sixteen clock edges");

    property p_load;
        @(posedge core_clk) disable iff (reset)
        start && !wr_now |=> state_r == umspi_pkg::UMSPI_LEAD && !tx_full_r;
    endproperty
    a_load: assert property (p_load) // RULE6
        else $error("holding register not moved to shifter");

    property p_no_tx_no_clock;
        @(posedge core_clk) disable iff (reset)
        !tx_on_r && state_r == umspi_pkg::UMSPI_IDLE |=> state_r == umspi_pkg::UMSPI_IDLE;
    endproperty
    a_no_tx_no_clock: assert property (p_no_tx_no_clock) // RULE1
        else $error("frame started without transmitter");

    property p_txc_set;
        @(posedge core_clk) disable iff (reset)
        frame_done && !tx_full_r |=> txc_r;
    endproperty
    a_txc_set: assert property (p_txc_set) // RULE16
        else $error("transmit complete not set after last frame");

    property p_status_zero;
        @(posedge core_clk) disable iff (reset)
        rd_done_r && ap_r.addr == `UMSPI_OFS_STATUS |-> hrdata[4:0] == 5'h00;
    endproperty
    a_status_zero: assert property (p_status_zero) // RULE9
        else $error("error flags not zero");

    property p_flush;
        @(posedge core_clk) disable iff (reset)
        !en_r[`UMSPI_EN_RXEN] |=> !rxc;
    endproperty
    a_flush: assert property (p_flush) // RULE15
        else $error("receive buffer kept data while disabled");

    property p_rx_irq;
        @(posedge core_clk) disable iff (reset)
        frame_done && en_r[`UMSPI_EN_RXEN] && en_r[`UMSPI_EN_RXCIE]
        && global_irq_enable |=> rxc_irq_req;
    endproperty
    a_rx_irq: assert property (p_rx_irq) // RULE20
        else $error("receive interrupt request missing");
endmodule

// ### test/umspi_slave_model.sv
// SPI slave model, mode 0, echoes each byte in the next frame
`timescale 1ns/1ps
module umspi_slave_model (
    input  wire logic en,   // Master drives the clock pin
    input  wire logic sck,
    input  wire logic mosi,
    output logic      miso
);
    logic [7:0] tx_r = 8'hC3; // First reply, arbitrary
    logic [7:0] rx_r = 8'h00; // Bits gathered
    logic [2:0] fall_r = 3'h0; // Trailing edges seen
    assign miso = tx_r[7]; // MSB first
    // Sample on leading edge
    // Unknown-to-known steps of an undriven clock are not edges
    always @(posedge sck) begin
        if (en) begin
            rx_r <= {rx_r[6:0], mosi};
        end
    end
    // Shift on trailing edge; reload echo after the eighth
    always @(negedge sck) begin
        if (en) begin
            fall_r <= fall_r + 3'h1;
            tx_r   <= (fall_r == 3'h7) ? rx_r : {tx_r[6:0], 1'b0};
        end
    end
endmodule

// ### test/test_usart_master_spi_transfer.sv
// Register-level testbench for the SPI engine
`timescale 1ns/1ps
module test_usart_master_spi_transfer;
    logic        core_clk = 1'b0;
    logic        reset    = 1'b1;
    logic        hsel     = 1'b0;
    logic [31:0] haddr    = 32'h0;
    logic [1:0]  htrans   = 2'h0;
    logic        hwrite   = 1'b0;
    logic [31:0] hwdata   = 32'h0;
    logic [31:0] hrdata, rd;
    logic        hrdy, hresp, rxi, txi, dri, sck, sck_oe, mosi, mosi_oe, miso, claim;
    int          errors = 0;
    int          checks_done = 0;
    always #2.5 core_clk = ~core_clk;
    umspi_top i_dut (.core_clk(core_clk), .reset(reset), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hrdata(hrdata),
        .hreadyout(hrdy), .hresp(hresp), .hready(hrdy), .global_irq_enable(1'b1),
        .txc_irq_taken(1'b0), .rxc_irq_req(rxi), .txc_irq_req(txi), .dre_irq_req(dri),
        .transfer_clock_pin(sck), .transfer_clock_oe(sck_oe), .serial_out_pin(mosi),
        .serial_out_oe(mosi_oe), .serial_in_pin(miso), .serial_in_claim(claim));
    umspi_slave_model i_slave (.en(sck_oe), .sck(sck), .mosi(mosi), .miso(miso));
    task automatic close_out;
        if (errors == 0 && checks_done > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        checks_done++;
        if (g !== e) begin
            errors++;
            $display("unexpected %s: expected %h, seen %h", nm, e, g);
        end
    endtask
    // One AHB single transfer; read data lands in rd
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge core_clk);
        hsel   <= 1'b1;
        htrans <= 2'h2;
        hwrite <= w;
        haddr  <= {24'h0, a};
        do @(posedge core_clk); while (hrdy !== 1'b1);
        hsel   <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge core_clk); while (hrdy !== 1'b1);
        rd = hrdata;
    endtask
    // Poll a status bit until set
    task automatic wait_st(input int b);
        do bus(1'b0, 8'h04, 32'h0); while (rd[b] !== 1'b1);
    endtask
    task automatic put(input logic [7:0] d);
        wait_st(5);
        bus(1'b1, 8'h00, {24'h0, d});
    endtask
    initial begin
        #100000;
        errors++;
        close_out();
    end
    initial begin
        repeat (12) @(posedge core_clk);
        reset <= 1'b0;
        bus(1'b0, 8'h04, 32'h0);
        chk("status", 32'h20, rd);
        bus(1'b0, 8'h08, 32'h0);
        chk("enables", 32'h06, rd);
        bus(1'b0, 8'h40, 32'h0);
        chk("unmapped", 32'h0, rd);
        bus(1'b1, 8'h0C, 32'hC0);
        bus(1'b1, 8'h08, 32'h98);
        // Transmitter ownership follows the enable one cycle later
        repeat (2) @(negedge core_clk);
        chk("claims", 32'h7, {29'h0, sck_oe, mosi_oe, claim});
        put(8'hA5);
        put(8'h5A);
        put(8'h0F);
        wait_st(6);
        chk("status full", 32'hE0, rd);
        chk("rx irq", 32'h1, {31'h0, rxi});
        chk("resp dre irq", 32'h0, {30'h0, hresp, dri});
        chk("sck idle", 32'h0, {31'h0, sck});
        bus(1'b0, 8'h00, 32'h0);
        chk("rx1", 32'hC3, rd);
        bus(1'b0, 8'h00, 32'h0);
        chk("rx2", 32'hA5, rd);
        bus(1'b1, 8'h04, 32'h40);
        bus(1'b0, 8'h04, 32'h0);
        chk("txc cleared", 32'h20, rd);
        put(8'h3C);
        wait_st(7);
        bus(1'b0, 8'h00, 32'h0);
        chk("rx echo", 32'h0F, rd);
        put(8'h77);
        wait_st(7);
        bus(1'b1, 8'h08, 32'h08);
        bus(1'b0, 8'h04, 32'h0);
        chk("flushed", 32'h0, {24'h0, rd[7], 7'h0});
        // LSB first at half the old rate; slave reverses, so its echo comes back intact
        bus(1'b1, 8'h0C, 32'hC4);
        bus(1'b1, 8'h10, 32'h1);
        bus(1'b0, 8'h10, 32'h0);
        chk("baud", 32'h1, rd);
        bus(1'b1, 8'h08, 32'h98);
        put(8'h12);
        wait_st(7);
        bus(1'b0, 8'h00, 32'h0);
        chk("rx lsb", 32'hEE, rd);
        put(8'h00);
        wait_st(7);
        bus(1'b0, 8'h00, 32'h0);
        chk("rx lsb echo", 32'h12, rd);
        close_out();
    end
endmodule
